// >>> hdl/stdc_defs.vh
`ifndef STDC_DEFS_VH
`define STDC_DEFS_VH
// register indices
`define STDC_ADDR_W 7
`define STDC_REG_HS_SEL 7'h48
`define STDC_REG_PURPOSE 7'h49
`define STDC_REG_BUS_TEST 7'h4c
`define STDC_REG_FIFO_PAR 7'h4d
`define STDC_REG_DIAG 7'h4e
`define STDC_REG_INT_STAT 7'h43
`define STDC_REG_INT_EN 7'h41
// field positions
`define STDC_HS_MSB 7
`define STDC_HS_LSB 4
`define STDC_SEL_MSB 3
`define STDC_SEL_LSB 0
`define STDC_BIT_HS 0
`define STDC_BIT_GEN 1
`define STDC_BIT_STO 2
`define STDC_BIT_FORCE 7
`define STDC_BIT_CLROFS 6
`define STDC_BIT_BAL 5
`define STDC_BIT_LOOP 4
`define STDC_BIT_HIZ 3
`define STDC_BIT_WIDE 2
`define STDC_BIT_EXTF 1
`define STDC_BIT_LOW 0
// reset values
`define STDC_DIAG_RST 8'h00
`define STDC_CFG_RST 8'h00
// timing
`define STDC_CLK_NS 50
`define STDC_BASE_TICK_NS 100000
`define STDC_SEL_ABORT_NS 200000
`define STDC_BASE_CYC (`STDC_BASE_TICK_NS / `STDC_CLK_NS)
// 200 us abort time counted in 100 us ticks
`define STDC_ABORT_TICKS 15'd2
`define STDC_FILT_SHORT 2
`define STDC_FILT_LONG 4
`endif

// >>> hdl/stdc_timer_diag.v
`timescale 1ns/100ps
`default_nettype none
`include "stdc_defs.vh"
module stdc_timer_diag #(
   parameter BASE_CYC = `STDC_BASE_CYC,
   parameter OFS_W = 4
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_arst_n,
   // register port
   input wire [6:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // core status inputs
   input wire i_is_target,
   input wire i_sel_attempt,
   input wire i_sel_done,
   input wire i_gen_enable,
   input wire i_select_ready,
   input wire i_arb_highest,
   input wire i_ofs_inc,
   input wire i_ofs_dec,
   input wire [OFS_W-1:0] i_ofs_max,
   input wire i_fifo_par_hi,
   input wire i_fifo_par_lo,
   input wire i_fifo_par_load,
   input wire i_start_seq,
   // raw bus handshake lines, active high
   input wire i_req_raw,
   input wire i_ack_raw,
   // control and data output latch and core values
   input wire [8:0] i_ctl_latch,
   input wire [17:0] i_data_latch,
   input wire [8:0] i_core_ctl,
   input wire [17:0] i_core_data,
   // bus drive, enables high while driving
   output reg [8:0] o_ctl_out,
   output reg [8:0] o_ctl_oe,
   output reg [17:0] o_data_out,
   output reg o_data_oe,
   output reg o_bsy_oe,
   output reg o_sel_oe,
   output reg o_rst_oe,
   // filtered handshake and mode outputs
   output reg o_req_filt,
   output reg o_ack_filt,
   output reg o_loop_both_roles,
   output reg o_wide_all,
   output reg o_dma_allow,
   output reg o_fetch_allow,
   output reg o_start_sel,
   output reg o_irq
);

   reg [7:0] hs_sel_cfg;
   reg [3:0] gen_cfg;
   reg [7:0] diag;
   reg [2:0] int_en;
   reg [2:0] int_stat;
   reg [OFS_W-1:0] sync_ofs;
   reg [1:0] fifo_par;
   reg [15:0] pre_cnt;
   reg tick;
   reg [14:0] hs_cnt;
   reg [14:0] sel_cnt;
   reg [14:0] gen_cnt;
   reg hs_run;
   reg sel_run;
   reg gen_run;
   reg [2:0] req_hold;
   reg [2:0] ack_hold;
   reg hs_prev;
   wire hs_line;
   wire hs_edge;
   wire rd_stat;
   wire [2:0] events;
   wire [7:0] diag_view;
   reg [7:0] next_rdata;
   // abort time rides on top of every selection period
   localparam [14:0] ABORT_TICKS = `STDC_ABORT_TICKS;

   // code 1 -> 1 tick, code n -> 2^(n-1) ticks; last code 15 gives 2^14 ticks
   function [14:0] limit_of;
      input [3:0] code;
      begin
         limit_of = 15'h0001 << (code - 4'h1);
      end
   endfunction

   // long hold would swallow valid pulses on fast transfers
   function [2:0] filt_len;
      input longer_deassert_filter;
      begin
         filt_len = longer_deassert_filter ? 3'd`STDC_FILT_LONG : 3'd`STDC_FILT_SHORT;
      end
   endfunction

   // prescaler: one enable pulse per 100 us
   // free running: expiry lands up to one tick late, never early
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pre_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (pre_cnt == BASE_CYC - 1) begin
         pre_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // deassert filter: assertion passes at once, release needs stable low
   // hold saturates, so a mode change mid-release cannot wrap it
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_hold <= 3'h0;
         o_req_filt <= 1'b0;
      end else if (i_req_raw) begin
         req_hold <= 3'h0;
         o_req_filt <= 1'b1;
      end else if (req_hold >= filt_len(diag[`STDC_BIT_EXTF])) begin
         o_req_filt <= 1'b0;
      end else begin
         req_hold <= req_hold + 3'h1;
      end
   end

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_hold <= 3'h0;
         o_ack_filt <= 1'b0;
      end else if (i_ack_raw) begin
         ack_hold <= 3'h0;
         o_ack_filt <= 1'b1;
      end else if (ack_hold >= filt_len(diag[`STDC_BIT_EXTF])) begin
         o_ack_filt <= 1'b0;
      end else begin
         ack_hold <= ack_hold + 3'h1;
      end
   end

   // target times req spacing, initiator times ack spacing
   assign hs_line = i_is_target ? o_req_filt : o_ack_filt;
   // filtered rising edge restarts the gap count
   assign hs_edge = hs_line & ~hs_prev;
   assign rd_stat = i_rd && (i_addr == `STDC_REG_INT_STAT);

   assign events[`STDC_BIT_HS] = hs_run && tick &&
      (hs_cnt == limit_of(hs_sel_cfg[`STDC_HS_MSB:`STDC_HS_LSB]));
   assign events[`STDC_BIT_STO] = sel_run && tick &&
      (sel_cnt == limit_of(hs_sel_cfg[`STDC_SEL_MSB:`STDC_SEL_LSB]) +
       ABORT_TICKS);
   assign events[`STDC_BIT_GEN] = gen_run && tick &&
      (gen_cnt == limit_of(gen_cfg));

   // timers
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hs_prev <= 1'b0;
         hs_run <= 1'b0;
         sel_run <= 1'b0;
         gen_run <= 1'b0;
         hs_cnt <= 15'h0000;
         sel_cnt <= 15'h0000;
         gen_cnt <= 15'h0000;
      end else begin
         hs_prev <= hs_line;
         // zero hs code keeps the handshake timer idle
         if (hs_sel_cfg[`STDC_HS_MSB:`STDC_HS_LSB] == 4'h0) begin
            hs_run <= 1'b0;
         end else if (hs_edge) begin
            hs_run <= 1'b1;
            hs_cnt <= 15'h0000;
         end else if (events[`STDC_BIT_HS]) begin
            // one expiry per gap; the next edge re-arms it
            hs_run <= 1'b0;
         end else if (hs_run && tick) begin
            hs_cnt <= hs_cnt + 15'h0001;
         end
         // an attempt still held re-arms the timer after a timeout
         if (hs_sel_cfg[`STDC_SEL_MSB:`STDC_SEL_LSB] == 4'h0 ||
            i_sel_done) begin
            sel_run <= 1'b0;
         end else if (i_sel_attempt && !sel_run) begin
            sel_run <= 1'b1;
            sel_cnt <= 15'h0000;
         end else if (events[`STDC_BIT_STO]) begin
            sel_run <= 1'b0;
         end else if (sel_run && tick) begin
            sel_cnt <= sel_cnt + 15'h0001;
         end
         // measured from enabling to disabling
         if (gen_cfg == 4'h0 || !i_gen_enable) begin
            gen_run <= 1'b0;
            gen_cnt <= 15'h0000;
         end else if (!gen_run && gen_cnt == 15'h0000) begin
            gen_run <= 1'b1;
         end else if (events[`STDC_BIT_GEN]) begin
            // parked count: no restart until the enable drops
            gen_run <= 1'b0;
            gen_cnt <= 15'h7fff;
         end else if (gen_run && tick) begin
            gen_cnt <= gen_cnt + 15'h0001;
         end
      end
   end

   // registers, status flags, offset counter
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hs_sel_cfg <= `STDC_CFG_RST;
         gen_cfg <= 4'h0;
         diag <= `STDC_DIAG_RST;
         int_en <= 3'h0;
         int_stat <= 3'h0;
         sync_ofs <= {OFS_W{1'b0}};
         fifo_par <= 2'h0;
      end else begin
         // set wins over read-clear
         int_stat <= (rd_stat ? 3'h0 : int_stat) | events;
         if (i_fifo_par_load) begin
            fifo_par <= {i_fifo_par_hi, i_fifo_par_lo};
         end
         diag[`STDC_BIT_CLROFS] <= 1'b0;
         // offset clear beats counting; inc and dec together cancel
         if (diag[`STDC_BIT_CLROFS]) begin
            sync_ofs <= {OFS_W{1'b0}};
         end else if (i_ofs_inc && !i_ofs_dec) begin
            sync_ofs <= sync_ofs + 1'b1;
         end else if (i_ofs_dec && !i_ofs_inc && sync_ofs != 0) begin
            sync_ofs <= sync_ofs - 1'b1;
         end
         if (i_wr) begin
            case (i_addr)
               `STDC_REG_HS_SEL: hs_sel_cfg <= i_wdata;
               `STDC_REG_PURPOSE: gen_cfg <= i_wdata[3:0];
               `STDC_REG_DIAG: diag <= i_wdata;
               `STDC_REG_INT_EN: int_en <= i_wdata[2:0];
               default: ;
            endcase
         end
      end
   end

   assign diag_view = diag;

   always @* begin
      case (i_addr)
         `STDC_REG_HS_SEL: next_rdata = hs_sel_cfg;
         `STDC_REG_PURPOSE: next_rdata = {4'h0, gen_cfg};
         `STDC_REG_BUS_TEST: next_rdata = {4'h0, i_select_ready,
            i_arb_highest,
            sync_ofs == {OFS_W{1'b0}},
            sync_ofs == i_ofs_max};
         `STDC_REG_FIFO_PAR: next_rdata = {6'h00, fifo_par};
         `STDC_REG_DIAG: next_rdata = diag_view;
         `STDC_REG_INT_STAT: next_rdata = {5'h00, int_stat};
         `STDC_REG_INT_EN: next_rdata = {5'h00, int_en};
         default: next_rdata = 8'h00;
      endcase
   end

   // outputs, all registered
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 8'h00;
         o_ctl_out <= 9'h000;
         o_ctl_oe <= 9'h000;
         o_data_out <= 18'h00000;
         o_data_oe <= 1'b0;
         o_bsy_oe <= 1'b0;
         o_sel_oe <= 1'b0;
         o_rst_oe <= 1'b0;
         o_loop_both_roles <= 1'b0;
         o_wide_all <= 1'b0;
         o_dma_allow <= 1'b0;
         o_fetch_allow <= 1'b0;
         o_start_sel <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         // read data only in the cycle after the strobe
         o_rdata <= i_rd ? next_rdata : 8'h00;
         // latches stay usable outside low-level mode
         if (diag[`STDC_BIT_FORCE]) begin
            o_ctl_out <= i_ctl_latch;
            o_data_out <= i_data_latch;
         end else begin
            o_ctl_out <= i_core_ctl;
            o_data_out <= i_core_data;
         end
         // open drain: drive only asserted lines; hi-z overrides all
         o_ctl_oe <= diag[`STDC_BIT_HIZ] ? 9'h000 :
            ((diag[`STDC_BIT_FORCE] ? i_ctl_latch : i_core_ctl) &
            {6'h3f, {3{~diag[`STDC_BIT_BAL]}}});
         // hi-z floats everything, even under force
         o_data_oe <= ~diag[`STDC_BIT_HIZ];
         // bits 0..2 of the control group are bsy, sel, rst
         o_bsy_oe <= ~diag[`STDC_BIT_BAL] & ~diag[`STDC_BIT_HIZ] &
            (diag[`STDC_BIT_FORCE] ? i_ctl_latch[0] : i_core_ctl[0]);
         o_sel_oe <= ~diag[`STDC_BIT_BAL] & ~diag[`STDC_BIT_HIZ] &
            (diag[`STDC_BIT_FORCE] ? i_ctl_latch[1] : i_core_ctl[1]);
         o_rst_oe <= ~diag[`STDC_BIT_BAL] & ~diag[`STDC_BIT_HIZ] &
            (diag[`STDC_BIT_FORCE] ? i_ctl_latch[2] : i_core_ctl[2]);
         o_loop_both_roles <= diag[`STDC_BIT_LOOP];
         o_wide_all <= diag[`STDC_BIT_WIDE];
         o_dma_allow <= ~diag[`STDC_BIT_LOW];
         o_fetch_allow <= ~diag[`STDC_BIT_LOW];
         // start request only honoured in low-level mode
         o_start_sel <= diag[`STDC_BIT_LOW] & i_start_seq;
         o_irq <= |(int_stat & int_en);
      end
   end

endmodule
`default_nettype wire

// >>> tb/stdc_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "stdc_defs.vh"
module stdc_props (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // stimulus
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_req_raw,
   input wire logic i_ack_raw,
   input wire logic [8:0] i_ctl_latch,
   input wire logic i_start_seq,
   input wire logic [17:0] i_data_latch,
   // observed
   input wire logic [8:0] o_ctl_out,
   input wire logic o_ack_filt,
   input wire logic [8:0] o_ctl_oe,
   input wire logic [17:0] o_data_out,
   input wire logic o_data_oe,
   input wire logic o_bsy_oe,
   input wire logic o_sel_oe,
   input wire logic o_rst_oe,
   input wire logic o_req_filt,
   input wire logic o_loop_both_roles,
   input wire logic o_wide_all,
   input wire logic o_dma_allow,
   input wire logic o_fetch_allow,
   input wire logic o_start_sel
);
   // shadow of diag control; the clear bit never sticks
   logic [7:0] diag;
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n)
         diag <= 8'h00;
      else if (i_wr && i_addr == `STDC_REG_DIAG)
         diag <= i_wdata & 8'hbf;
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   sequence s_rise;
      $rose(i_req_raw);
   endsequence
   sequence s_ack_rise;
      $rose(i_ack_raw);
   endsequence
   sequence s_drop;
      o_req_filt && $fell(i_req_raw);
   endsequence
   req_assert_a: assert property (s_rise |-> ##[1:2] o_req_filt)
      else $error("filtered request late");
   req_glitch_a: assert property (s_drop |=> o_req_filt)
      else $error("request release passed too early");
   bal_tristate_a: assert property (diag[5] && $past(diag[5])
      |-> !(o_bsy_oe || o_sel_oe || o_rst_oe || |o_ctl_oe[2:0]))
      else $error("balanced mode still drives");
   hiz_float_a: assert property (diag[3] && $past(diag[3])
      |-> o_ctl_oe == 9'h000 && !o_data_oe && !o_bsy_oe && !o_sel_oe)
      else $error("hi-z mode still drives");
   loop_roles_a: assert property (diag[4] == $past(diag[4])
      |-> o_loop_both_roles == diag[4])
      else $error("loopback output wrong");
   wide_all_a: assert property (diag[2] == $past(diag[2])
      |-> o_wide_all == diag[2])
      else $error("always-wide output wrong");
   low_stop_a: assert property (diag[0] && $past(diag[0])
      |-> !o_dma_allow && !o_fetch_allow)
      else $error("low-level mode still allows dma");
   start_sel_a: assert property (diag[0] && i_start_seq
      |=> o_start_sel)
      else $error("start sequence not passed");
   force_data_a: assert property (diag[7] && $past(diag[7])
      && $stable(i_data_latch) |-> o_data_out == i_data_latch)
      else $error("forced data not from latch");
   ack_assert_a: assert property (s_ack_rise |-> ##[1:2] o_ack_filt)
      else $error("filtered acknowledge late");
   force_ctl_a: assert property (diag[7] && $past(diag[7])
      && $stable(i_ctl_latch) |-> o_ctl_out == i_ctl_latch)
      else $error("forced control not from latch");
endmodule
bind stdc_timer_diag stdc_props u_props (.i_clk_sys, .i_arst_n, .i_addr,
   .i_wdata, .i_wr, .i_req_raw, .i_ack_raw, .i_start_seq, .i_data_latch,
   .i_ctl_latch, .o_ctl_out, .o_ack_filt, .o_ctl_oe,
   .o_data_out, .o_data_oe, .o_bsy_oe, .o_sel_oe, .o_rst_oe, .o_req_filt,
   .o_loop_both_roles, .o_wide_all, .o_dma_allow, .o_fetch_allow,
   .o_start_sel);
`default_nettype wire

// >>> tb/stdc_bus_peer.sv
`timescale 1ns/100ps
`default_nettype none
module stdc_bus_peer (
   // control
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_target,
   input wire logic i_glitch,
   // raw handshake lines, released low
   output logic o_req,
   output logic o_ack
);
   // pulses stay several cycles wide: slow rate only
   logic [11:0] pat = 12'h000;
   always @(posedge i_clk) begin
      if (i_go)
         pat <= i_glitch ? 12'h7b8 : 12'h0f0;
      else
         pat <= pat >> 1;
   end
   assign o_req = i_target & pat[0];
   assign o_ack = !i_target & pat[0];
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "stdc_defs.vh"
module testbench;
   logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [6:0] i_addr = 7'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_is_target = 1'b0, i_sel_attempt = 1'b0, i_sel_done = 1'b0;
   logic i_gen_enable = 1'b0, i_select_ready = 1'b0, i_arb_highest = 1'b0;
   logic i_ofs_inc = 1'b0, i_ofs_dec = 1'b0, i_start_seq = 1'b0;
   logic i_fifo_par_hi = 1'b0, i_fifo_par_lo = 1'b0, i_fifo_par_load = 1'b0;
   logic [3:0] i_ofs_max = 4'h3;
   logic [8:0] i_ctl_latch = 9'h0a5, i_core_ctl = 9'h1c7;
   logic [17:0] i_data_latch = 18'h2a5a5, i_core_data = 18'h00000;
   logic go = 1'b0, glitch = 1'b0;
   wire i_req_raw, i_ack_raw, o_irq, o_dma_allow, req_filt;
   wire [7:0] o_rdata;
   int miscompares = 0, tests_run = 0, n;
   always #25 i_clk_sys = ~i_clk_sys;
   stdc_timer_diag #(.BASE_CYC(4)) dut (.i_clk_sys, .i_arst_n, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_is_target, .i_sel_attempt,
      .i_sel_done, .i_gen_enable, .i_select_ready, .i_arb_highest,
      .i_ofs_inc, .i_ofs_dec, .i_ofs_max, .i_fifo_par_hi, .i_fifo_par_lo,
      .i_fifo_par_load, .i_start_seq, .i_req_raw, .i_ack_raw, .i_ctl_latch,
      .i_data_latch, .i_core_ctl, .i_core_data, .o_ctl_out(), .o_ctl_oe(),
      .o_data_out(), .o_data_oe(), .o_bsy_oe(), .o_sel_oe(), .o_rst_oe(),
      .o_req_filt(req_filt), .o_ack_filt(), .o_loop_both_roles(),
      .o_wide_all(),
      .o_dma_allow, .o_fetch_allow(), .o_start_sel(), .o_irq);
   stdc_bus_peer peer (.i_clk(i_clk_sys), .i_go(go), .i_target(i_is_target),
      .i_glitch(glitch), .o_req(i_req_raw), .o_ack(i_ack_raw));
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (o_irq !== 1'b1) begin
         @(posedge i_clk_sys);
         #1;
         n++;
         if (n > lim) begin
            miscompares++;
            summarize();
         end
      end
   endtask
   task automatic bump(input logic up);
      @(posedge i_clk_sys);
      i_ofs_inc <= up;
      i_ofs_dec <= !up;
      @(posedge i_clk_sys);
      i_ofs_inc <= 1'b0;
      i_ofs_dec <= 1'b0;
   endtask
   task automatic fire(input logic tgt, input logic gl);
      i_is_target <= tgt;
      glitch <= gl;
      go <= 1'b1;
      @(posedge i_clk_sys);
      go <= 1'b0;
   endtask
   task automatic t_diag;
      rdc(7'h7f, 8'h00);
      i_start_seq <= 1'b1;
      for (int b = 7; b >= 0; b--) begin
         wr(`STDC_REG_DIAG, 8'h01 << b);
         repeat (3) @(posedge i_clk_sys);
         rdc(`STDC_REG_DIAG, (b == 6) ? 8'h00 : 8'h01 << b);
      end
      chk(o_dma_allow, 1'b0);
      wr(`STDC_REG_DIAG, 8'h00);
      repeat (2) @(posedge i_clk_sys);
      chk(o_dma_allow, 1'b1);
      i_start_seq <= 1'b0;
   endtask
   task automatic t_ofs;
      repeat (3) bump(1'b1);
      wr(`STDC_REG_BUS_TEST, 8'hff);
      rdc(`STDC_REG_BUS_TEST, 8'h01);
      i_select_ready <= 1'b1;
      i_arb_highest <= 1'b1;
      bump(1'b0);
      rdc(`STDC_REG_BUS_TEST, 8'h0c);
      wr(`STDC_REG_DIAG, 8'h40);
      rdc(`STDC_REG_BUS_TEST, 8'h0e);
      for (int k = 1; k < 3; k++) begin
         i_fifo_par_hi <= k[1];
         i_fifo_par_lo <= k[0];
         i_fifo_par_load <= 1'b1;
         @(posedge i_clk_sys);
         i_fifo_par_load <= 1'b0;
         rdc(`STDC_REG_FIFO_PAR, k[7:0]);
      end
   endtask
   task automatic t_timers;
      wr(`STDC_REG_INT_EN, 8'h07);
      for (int c = 0; c < 5; c++) begin
         wr(`STDC_REG_PURPOSE, c[7:0]);
         i_gen_enable <= 1'b1;
         if (c == 0) begin
            repeat (60) @(posedge i_clk_sys);
            chk(o_irq, 1'b0);
         end else begin
            wait_irq(80);
            chk(n >= (4 << (c-1)) - 4 && n <= (4 << (c-1)) + 8, 1);
            rdc(`STDC_REG_INT_STAT, 8'h02);
         end
         rdc(`STDC_REG_INT_STAT, 8'h00);
         i_gen_enable <= 1'b0;
      end
      wr(`STDC_REG_INT_EN, 8'h01);
      wr(`STDC_REG_HS_SEL, 8'h10);
      fire(1'b1, 1'b1);
      wait_irq(40);
      rdc(`STDC_REG_INT_STAT, 8'h01);
      wr(`STDC_REG_INT_EN, 8'h00);
      fire(1'b0, 1'b0);
      repeat (40) @(posedge i_clk_sys);
      chk(o_irq, 1'b0);
      rdc(`STDC_REG_INT_STAT, 8'h01);
      wr(`STDC_REG_HS_SEL, 8'h01);
      wr(`STDC_REG_INT_EN, 8'h04);
      i_sel_attempt <= 1'b1;
      wait_irq(60);
      chk(n >= 8 && n <= 20, 1'b1);
      rdc(`STDC_REG_INT_STAT, 8'h04);
      i_sel_attempt <= 1'b0;
      i_sel_done <= 1'b1;
   endtask
   task automatic t_filt;
      for (int e = 0; e < 2; e++) begin
         wr(`STDC_REG_DIAG, e[0] ? 8'h02 : 8'h00);
         fire(1'b1, 1'b1);
         n = 0;
         repeat (24) begin
            @(posedge i_clk_sys);
            #1;
            if (req_filt === 1'b1)
               n++;
         end
         chk(n, e[0] ? 8 + `STDC_FILT_LONG : 8 + `STDC_FILT_SHORT);
      end
      wr(`STDC_REG_DIAG, 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      t_diag();
      t_ofs();
      t_filt();
      t_timers();
      summarize();
   end
endmodule
`default_nettype wire
